//--- rtl/ufps_map.svh
// Offsets, field positions, reset values and counts for the status block.
// Assumes word addressing on the plain register port.
`ifndef UFPS_MAP_SVH
`define UFPS_MAP_SVH
`define UFPS_NUM_INST 3
`define UFPS_ADDR_W 5
`define UFPS_DATA_W 16
`define UFPS_ENAB_W 15
`define UFPS_ADR_OPER_EVENT 5'h00
`define UFPS_ADR_OPER_COND 5'h01
`define UFPS_ADR_OPER_ENAB 5'h02
`define UFPS_ADR_QUES_EVENT 5'h03
`define UFPS_ADR_QUES_COND 5'h04
`define UFPS_ADR_QUES_ENAB 5'h05
`define UFPS_ADR_PRESET 5'h06
`define UFPS_ADR_ESE_ALIAS 5'h07
`define UFPS_ADR_FREQ_OBS 5'h08
`define UFPS_ADR_THRESH_BASE 5'h10
`define UFPS_ADR_ARM_BASE 5'h18
`define UFPS_THRESH_RST 16'h01C2
`define UFPS_OPER_ARMED_BIT 0
`define UFPS_QUES_TRIP_BIT 0
`endif

//--- rtl/ufps_pkg.sv
// Types shared by the status block.
// Assumes the map header is included alongside.
package ufps_pkg;
	typedef logic [15:0] ufps_word_t;
	typedef logic [4:0] ufps_addr_t;
endpackage : ufps_pkg

//--- rtl/ufps_regs.sv
// Under-frequency protection and status registers.
// Assumes a synchronous bus master on clk and a frequency word from another clock domain.
`timescale 1ns/1ps
`include "ufps_map.svh"
module ufps_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register port
	input wire ufps_pkg::ufps_addr_t reg_addr,
	input wire ufps_pkg::ufps_word_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output ufps_pkg::ufps_word_t reg_rdata,
	// Frequency measurement, tenths of hertz
	input wire ufps_pkg::ufps_word_t out_freq,
	// Trip outputs
	output logic [`UFPS_NUM_INST-1:0] under_freq_protect_trip,
	output logic under_freq_any_trip
);
	import ufps_pkg::*;

	localparam int N = `UFPS_NUM_INST;

	// Frequency synchroniser and word filter
	ufps_word_t freq_s1_reg, freq_s2_reg, freq_s3_reg, freq_hold_reg, freq_hold_next;
	// Accept a word only after two equal samples
	always_comb begin
		freq_hold_next = freq_hold_reg;
		if (freq_s2_reg == freq_s3_reg)
			freq_hold_next = freq_s2_reg;
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			freq_s1_reg <= 16'h0000;
			freq_s2_reg <= 16'h0000;
			freq_s3_reg <= 16'h0000;
			freq_hold_reg <= 16'h0000;
		end else begin
			freq_s1_reg <= out_freq;
			freq_s2_reg <= freq_s1_reg;
			freq_s3_reg <= freq_s2_reg;
			freq_hold_reg <= freq_hold_next;
		end
	end

	ufps_word_t thresh_reg [N];
	ufps_word_t thresh_next [N];
	logic [N-1:0] arm_reg, arm_next;
	logic [N-1:0] trip_reg, trip_next;
	logic [`UFPS_ENAB_W-1:0] oper_en_reg, oper_en_next;
	logic [`UFPS_ENAB_W-1:0] ques_en_reg, ques_en_next;
	ufps_word_t oper_ev_reg, oper_ev_next;
	ufps_word_t ques_ev_reg, ques_ev_next;
	ufps_word_t oper_cond_prev_reg, ques_cond_prev_reg;
	ufps_word_t oper_cond, ques_cond;
	ufps_word_t rdata_next;
	logic any_next;

	// Live condition bits
	always_comb begin
		oper_cond = 16'h0000;
		ques_cond = 16'h0000;
		oper_cond[`UFPS_OPER_ARMED_BIT] = |arm_reg;
		ques_cond[`UFPS_QUES_TRIP_BIT] = |trip_reg;
	end

	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_inst
			always_comb begin
				thresh_next[gi] = thresh_reg[gi];
				arm_next[gi] = arm_reg[gi];
				if (reg_wr && reg_addr == `UFPS_ADR_THRESH_BASE + 5'(gi))
					thresh_next[gi] = reg_wdata;
				if (reg_wr && reg_addr == `UFPS_ADR_ARM_BASE + 5'(gi))
					arm_next[gi] = reg_wdata[0];
				trip_next[gi] = arm_reg[gi] && (freq_hold_reg < thresh_reg[gi]);
			end
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					thresh_reg[gi] <= `UFPS_THRESH_RST;
					arm_reg[gi] <= 1'b0;
					trip_reg[gi] <= 1'b0;
				end else begin
					thresh_reg[gi] <= thresh_next[gi];
					arm_reg[gi] <= arm_next[gi];
					trip_reg[gi] <= trip_next[gi];
				end
			end
		end
	endgenerate

	// Status group next state
	always_comb begin
		oper_en_next = oper_en_reg;
		ques_en_next = ques_en_reg;
		oper_ev_next = oper_ev_reg;
		ques_ev_next = ques_ev_reg;
		if (reg_wr && (reg_addr == `UFPS_ADR_OPER_ENAB || reg_addr == `UFPS_ADR_ESE_ALIAS))
			oper_en_next = reg_wdata[`UFPS_ENAB_W-1:0];
		if (reg_wr && reg_addr == `UFPS_ADR_QUES_ENAB)
			ques_en_next = reg_wdata[`UFPS_ENAB_W-1:0];
		if (reg_wr && reg_addr == `UFPS_ADR_PRESET) begin
			oper_en_next = 15'h0000;
			ques_en_next = 15'h0000;
		end
		if (reg_rd && reg_addr == `UFPS_ADR_OPER_EVENT)
			oper_ev_next = 16'h0000;
		if (reg_rd && reg_addr == `UFPS_ADR_QUES_EVENT)
			ques_ev_next = 16'h0000;
		oper_ev_next = oper_ev_next | (oper_cond & ~oper_cond_prev_reg);
		ques_ev_next = ques_ev_next | (ques_cond & ~ques_cond_prev_reg);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			oper_en_reg <= 15'h0000;
			ques_en_reg <= 15'h0000;
			oper_ev_reg <= 16'h0000;
			ques_ev_reg <= 16'h0000;
			oper_cond_prev_reg <= 16'h0000;
			ques_cond_prev_reg <= 16'h0000;
		end else begin
			oper_en_reg <= oper_en_next;
			ques_en_reg <= ques_en_next;
			oper_ev_reg <= oper_ev_next;
			ques_ev_reg <= ques_ev_next;
			oper_cond_prev_reg <= oper_cond;
			ques_cond_prev_reg <= ques_cond;
		end
	end

	// Read mux
	always_comb begin
		rdata_next = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				`UFPS_ADR_OPER_EVENT: rdata_next = oper_ev_reg;
				`UFPS_ADR_OPER_COND: rdata_next = oper_cond;
				`UFPS_ADR_OPER_ENAB: rdata_next = {1'b0, oper_en_reg};
				`UFPS_ADR_ESE_ALIAS: rdata_next = {1'b0, oper_en_reg};
				`UFPS_ADR_QUES_EVENT: rdata_next = ques_ev_reg;
				`UFPS_ADR_QUES_COND: rdata_next = ques_cond;
				`UFPS_ADR_QUES_ENAB: rdata_next = {1'b0, ques_en_reg};
				`UFPS_ADR_FREQ_OBS: rdata_next = freq_hold_reg;
				default: begin
					for (int i = 0; i < N; i++) begin
						if (reg_addr == `UFPS_ADR_THRESH_BASE + 5'(i))
							rdata_next = thresh_reg[i];
						if (reg_addr == `UFPS_ADR_ARM_BASE + 5'(i))
							rdata_next = {15'h0000, arm_reg[i]};
					end
				end
			endcase
		end
		any_next = |trip_next;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= 16'h0000;
			under_freq_any_trip <= 1'b0;
		end else begin
			reg_rdata <= rdata_next;
			under_freq_any_trip <= any_next;
		end
	end

	assign under_freq_protect_trip = trip_reg;

	property p_trip;
		@(posedge clk) disable iff (sys_rst)
		(arm_reg[0] && freq_hold_reg < thresh_reg[0]) |=> trip_reg[0];
	endproperty
	a_trip: assert property (p_trip) else $error("trip missed");

	property p_noarm;
		@(posedge clk) disable iff (sys_rst)
		!arm_reg[0] |=> !trip_reg[0];
	endproperty
	a_noarm: assert property (p_noarm) else $error("disarmed trip");

	property p_thr;
		@(posedge clk) disable iff (sys_rst)
		(reg_wr && reg_addr == `UFPS_ADR_THRESH_BASE) ##1
		(reg_rd && reg_addr == `UFPS_ADR_THRESH_BASE) |=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_thr: assert property (p_thr) else $error("threshold readback");

	property p_arm;
		@(posedge clk) disable iff (sys_rst)
		(reg_wr && reg_addr == `UFPS_ADR_ARM_BASE) |=> arm_reg[0] == $past(reg_wdata[0]);
	endproperty
	a_arm: assert property (p_arm) else $error("arm write");

	property p_oev;
		@(posedge clk) disable iff (sys_rst)
		(reg_rd && reg_addr == `UFPS_ADR_OPER_EVENT) |=> reg_rdata == $past(oper_ev_reg);
	endproperty
	a_oev: assert property (p_oev) else $error("oper event read");

	property p_qcond;
		@(posedge clk) disable iff (sys_rst)
		(reg_rd && reg_addr == `UFPS_ADR_QUES_COND) |=> reg_rdata[0] == $past(|trip_reg);
	endproperty
	a_qcond: assert property (p_qcond) else $error("ques cond read");

	property p_oen;
		@(posedge clk) disable iff (sys_rst)
		(reg_wr && reg_addr == `UFPS_ADR_OPER_ENAB) |=> oper_en_reg == $past(reg_wdata[14:0]);
	endproperty
	a_oen: assert property (p_oen) else $error("oper enable store");

	property p_pre;
		@(posedge clk) disable iff (sys_rst)
		(reg_wr && reg_addr == `UFPS_ADR_PRESET) |=> (oper_en_reg == 15'h0000 && ques_en_reg == 15'h0000);
	endproperty
	a_pre: assert property (p_pre) else $error("preset failed");

	property p_latch;
		@(posedge clk) disable iff (sys_rst)
		$rose(ques_cond[0]) |=> ques_ev_reg[0];
	endproperty
	a_latch: assert property (p_latch) else $error("event not latched");

	property p_ocond;
		@(posedge clk) disable iff (sys_rst)
		(reg_rd && reg_addr == `UFPS_ADR_OPER_COND) |=> reg_rdata[0] == $past(|arm_reg);
	endproperty
	a_ocond: assert property (p_ocond) else $error("oper cond read");

	property p_qev;
		@(posedge clk) disable iff (sys_rst)
		(reg_rd && reg_addr == `UFPS_ADR_QUES_EVENT) |=> reg_rdata == $past(ques_ev_reg);
	endproperty
	a_qev: assert property (p_qev) else $error("ques event read");

	property p_qen;
		@(posedge clk) disable iff (sys_rst)
		(reg_wr && reg_addr == `UFPS_ADR_QUES_ENAB) |=> ques_en_reg == $past(reg_wdata[14:0]);
	endproperty
	a_qen: assert property (p_qen) else $error("ques enable store");

	property p_alias;
		@(posedge clk) disable iff (sys_rst)
		(reg_wr && reg_addr == `UFPS_ADR_ESE_ALIAS) |=> oper_en_reg == $past(reg_wdata[14:0]);
	endproperty
	a_alias: assert property (p_alias) else $error("alias store");

	property p_alrd;
		@(posedge clk) disable iff (sys_rst)
		(reg_rd && reg_addr == `UFPS_ADR_ESE_ALIAS) |=> reg_rdata == {1'b0, $past(oper_en_reg)};
	endproperty
	a_alrd: assert property (p_alrd) else $error("alias readback");

	property p_armrd;
		@(posedge clk) disable iff (sys_rst)
		(reg_rd && reg_addr == `UFPS_ADR_ARM_BASE) |=> reg_rdata == {15'h0000, $past(arm_reg[0])};
	endproperty
	a_armrd: assert property (p_armrd) else $error("arm readback");

	property p_thold;
		@(posedge clk) disable iff (sys_rst)
		!(reg_wr && reg_addr == `UFPS_ADR_THRESH_BASE) |=> $stable(thresh_reg[0]);
	endproperty
	a_thold: assert property (p_thold) else $error("threshold changed");

	property p_clr;
		@(posedge clk) disable iff (sys_rst)
		(reg_rd && reg_addr == `UFPS_ADR_OPER_EVENT && oper_cond == oper_cond_prev_reg)
		|=> oper_ev_reg == 16'h0000;
	endproperty
	a_clr: assert property (p_clr) else $error("event not cleared");

	property p_any;
		@(posedge clk) disable iff (sys_rst)
		under_freq_any_trip == (|under_freq_protect_trip);
	endproperty
	a_any: assert property (p_any) else $error("summary trip");
endmodule : ufps_regs

//--- tb/ufps_host.sv
// Host model: register port master and frequency source.
// Assumes one clock; the bench calls its tasks in sequence.
`timescale 1ns/1ps
module ufps_host (
	// Clock
	input wire logic clk,
	// Register port
	output ufps_pkg::ufps_addr_t reg_addr,
	output ufps_pkg::ufps_word_t reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire ufps_pkg::ufps_word_t reg_rdata,
	// Measured frequency
	output ufps_pkg::ufps_word_t out_freq
);
	import ufps_pkg::*;
	initial begin
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		out_freq = 16'h0258;
	end
	task wr(input ufps_addr_t a, input ufps_word_t d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask : wr
	// write then read back to back
	task wrd(input ufps_addr_t a, input ufps_word_t d, output ufps_word_t q);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		q = reg_rdata;
	endtask : wrd
	task rd(input ufps_addr_t a, output ufps_word_t d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask : rd
	task fq(input ufps_word_t f);
		@(posedge clk);
		out_freq <= f;
	endtask : fq
endmodule : ufps_host

//--- tb/ufps_regs_tb_top.sv
// Bench: host model drives the block, a reference model checks each read.
// Assumes the package and map header are compiled first.
`timescale 1ns/1ps
`include "ufps_map.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
	$display("Error %s exp %0h got %0h", n, e, g); end end
module ufps_regs_tb_top;
	import ufps_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	ufps_addr_t reg_addr;
	ufps_word_t reg_wdata, reg_rdata, out_freq, d;
	logic reg_wr, reg_rd, under_freq_any_trip;
	logic [`UFPS_NUM_INST-1:0] under_freq_protect_trip;
	int num_errors = 0, tests_run = 0, seed = 74, thr[3], arm[3], v, x, prv;
	int wa[3] = '{2, 7, 5}, ra[3] = '{7, 2, 5}, fl[4] = '{600, 500, 499, 0};
	always #20 clk = ~clk;
	ufps_regs u_ufps_regs (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.out_freq(out_freq), .under_freq_protect_trip(under_freq_protect_trip),
		.under_freq_any_trip(under_freq_any_trip));
	ufps_host u_ufps_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_freq(out_freq));
	function int xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task rc(input int a, input int e, input string n);
		u_ufps_host.rd(5'(a), d);
		`CHK(n, e, d)
	endtask : rc
	task print_verdict();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : print_verdict
	initial begin
		#200us;
		num_errors++;
		print_verdict();
	end
	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			rc(`UFPS_ADR_THRESH_BASE + i, `UFPS_THRESH_RST, "thr_rst");
			rc(`UFPS_ADR_ARM_BASE + i, 0, "arm_rst");
		end
		rc(5'h1F, 0, "unmapped");
		$display("reset test done");
		for (int j = 0; j < 3; j++) begin
			v = 16'(xs());
			u_ufps_host.wr(5'(wa[j]), 16'(v));
			rc(ra[j], v & 16'h7FFF, "enable");
		end
		u_ufps_host.wr(`UFPS_ADR_PRESET, 16'h0001);
		rc(`UFPS_ADR_OPER_ENAB, 0, "oper_enab");
		rc(`UFPS_ADR_QUES_ENAB, 0, "ques_enab");
		$display("enable test done");
		for (int i = 0; i < 3; i++) begin
			v = xs() & 32'h0000_FFFF;
			u_ufps_host.wrd(5'(`UFPS_ADR_THRESH_BASE + i), 16'(v), d);
			`CHK("thr", v, d)
			u_ufps_host.wr(5'(`UFPS_ADR_THRESH_BASE + i), 16'h01F4);
			thr[i] = 500;
			u_ufps_host.wr(5'(`UFPS_ADR_ARM_BASE + i), 16'h0001);
			arm[i] = 1;
			rc(`UFPS_ADR_ARM_BASE + i, 1, "arm");
		end
		rc(`UFPS_ADR_OPER_COND, 1, "oper_cond");
		rc(`UFPS_ADR_OPER_EVENT, 1, "oper_ev");
		rc(`UFPS_ADR_OPER_EVENT, 0, "oper_ev_clr");
		u_ufps_host.wr(5'(`UFPS_ADR_ARM_BASE + 1), 16'h0000);
		arm[1] = 0;
		rc(`UFPS_ADR_ARM_BASE + 1, 0, "disarm");
		$display("arm test done");
		prv = 0;
		foreach (fl[k]) begin
			u_ufps_host.fq(16'(fl[k]));
			repeat (6) @(posedge clk);
			@(negedge clk);
			x = 0;
			for (int i = 0; i < 3; i++) begin
				x |= int'(arm[i] != 0 && fl[k] < thr[i]) << i;
			end
			`CHK("trip", x, under_freq_protect_trip)
			`CHK("any_trip", x != 0, under_freq_any_trip)
			rc(`UFPS_ADR_QUES_COND, x != 0, "ques_cond");
			rc(`UFPS_ADR_FREQ_OBS, fl[k], "freq_obs");
			rc(`UFPS_ADR_QUES_EVENT, x != 0 && prv == 0, "ques_ev");
			prv = (x != 0);
		end
		$display("trip test done");
		print_verdict();
	end
endmodule : ufps_regs_tb_top
